/* File: hw/jesd_transport_octet_packer.sv */
// transport-layer packer: converter samples to lane octets, test pattern, scrambler
// assumes: samples and link phase come from logic on CLK; link layer drains OCT_*
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module jesd_transport_octet_packer (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [7:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_W,
   output logic [31:0] WB_DAT_R,
   output logic WB_ACK,
   input wire logic [packer_pkg::FRAME_W-1:0] SAMPLE_DATA,
   input wire logic SAMPLE_VALID,
   output logic SAMPLE_READY,
   input wire logic LINK_USER_PHASE,
   output logic [7:0] OCT_DATA,
   output logic OCT_LAST,
   output logic OCT_VALID,
   input wire logic OCT_READY
);
   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      return adr == ofs;
   endfunction

   // left-justify, bits above resolution fall off the top
   function automatic logic [15:0] justify(input logic [15:0] smp, input logic [4:0] res);
      return 16'(smp << (5'(packer_pkg::SAMPLE_W) - res));
   endfunction

   // self-synchronous 1 + x^14 + x^15, msb first
   function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
      logic [14:0] st;
      logic [7:0] o;
      st = s;
      o = 8'h00;
      for (int k = 7; k >= 0; k--) begin
         o[k] = d[k] ^ st[14] ^ st[13];
         st = {st[13:0], o[k]};
      end
      return {st, o};
   endfunction

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [31:0] ctrl_q;
   logic [15:0] tpat_q;
   logic [7:0] pdn_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic [4:0] len_q;
   logic busy;

   wire bus_req = WB_CYC && WB_STB && !ack_q;
   // writes land on the acking edge, when the master samples ack high
   wire wr_en = WB_CYC && WB_STB && WB_WE && ack_q && CE;
   wire hit_ctrl = hit(WB_ADR, packer_pkg::OFS_CTRL);
   wire hit_tpat = hit(WB_ADR, packer_pkg::OFS_TPAT);
   wire hit_pdn = hit(WB_ADR, packer_pkg::OFS_PDN);
   wire hit_stat = hit(WB_ADR, packer_pkg::OFS_STATUS);
   wire [31:0] status_w = (32'(len_q) << packer_pkg::LEN_LSB) | (32'(busy) << packer_pkg::BUSY_BIT);
   // unmapped addresses are acked and read as zero
   wire [31:0] rd_mux = hit_ctrl ? (ctrl_q & packer_pkg::CTRL_MASK) :
                        hit_tpat ? {16'h0000, tpat_q} :
                        hit_pdn ? {24'h000000, pdn_q} :
                        hit_stat ? status_w : 32'h00000000;

   assign WB_ACK = ack_q;
   assign WB_DAT_R = rdat_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else if (CE) begin
         ack_q <= bus_req;
         rdat_q <= bus_req ? rd_mux : 32'h00000000;
      end
   end

   for (genvar b = 0; b < 4; b++) begin : g_ctrl_lane
      always_ff @(posedge CLK) begin
         if (RST) begin
            ctrl_q[8*b+:8] <= packer_pkg::CTRL_RST[8*b+:8];
         end else if (wr_en && hit_ctrl && WB_SEL[b]) begin
            ctrl_q[8*b+:8] <= WB_DAT_W[8*b+:8];
         end
      end
   end

   for (genvar b = 0; b < 2; b++) begin : g_tpat_lane
      always_ff @(posedge CLK) begin
         if (RST) begin
            tpat_q[8*b+:8] <= packer_pkg::TPAT_RST[8*b+:8];
         end else if (wr_en && hit_tpat && WB_SEL[b]) begin
            tpat_q[8*b+:8] <= WB_DAT_W[8*b+:8];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pdn_q <= packer_pkg::PDN_RST;
      end else if (wr_en && hit_pdn && WB_SEL[0]) begin
         pdn_q <= WB_DAT_W[7:0];
      end
   end

   // ****************************************************************
   // layout decode
   // ****************************************************************
   wire [3:0] cpl_raw = ctrl_q[packer_pkg::CPL_LSB+:4];
   wire [4:0] res = ctrl_q[packer_pkg::RES_LSB+:5];
   wire [4:0] ser = ctrl_q[packer_pkg::SER_LSB+:5];
   wire single_mode = ctrl_q[packer_pkg::SINGLE_BIT];
   wire scrambler_enable = ctrl_q[packer_pkg::SCR_BIT];
   wire tp_en = ctrl_q[packer_pkg::TP_BIT];
   // unsupported lane counts fall back to eight
   wire [3:0] cpl = (cpl_raw == packer_pkg::CPL_TWO) ? packer_pkg::CPL_TWO :
                    (cpl_raw == packer_pkg::CPL_FOUR) ? packer_pkg::CPL_FOUR : packer_pkg::CPL_EIGHT;
   wire [4:0] res_nib = (res + packer_pkg::NIB_RND) & packer_pkg::NIB_MASK;
   // slot width per sample: fixed 16, nibble-rounded, or the serial width
   wire [4:0] slot_w = single_mode ? packer_pkg::W_SINGLE : // [RULE4]
                       (cpl == packer_pkg::CPL_TWO) ? res_nib : ser; // [RULE1] [RULE2] [RULE3]
   // octets per frame; a short lane count uses the head of the layout
   wire [4:0] len_w = 5'((8'(cpl) * 8'(slot_w)) >> 3); // [RULE5]
   wire [15:0] tp_just = justify(tpat_q, res);

   // ****************************************************************
   // frame assembly
   // ****************************************************************
   // one sample per converter per frame, no high-density layout
   wire [packer_pkg::FRAME_W-1:0] acc [0:packer_pkg::NCONV]; // [RULE8]
   wire [15:0] just [0:packer_pkg::NCONV-1];
   assign acc[0] = '0;
   for (genvar i = 0; i < packer_pkg::NCONV; i++) begin : g_slot
      wire [15:0] smp = SAMPLE_DATA[packer_pkg::SAMPLE_W*i+:packer_pkg::SAMPLE_W];
      wire used = (4'(i) < cpl);
      wire [15:0] src = tp_en ? tp_just : justify(smp, res); // [RULE9]
      // powered-down or unused slots carry zeros; low bits past resolution are zero tail
      assign just[i] = (used && !pdn_q[i]) ? src : 16'h0000; // [RULE7] [RULE6]
      wire [6:0] sh = 7'(i) * 7'(slot_w);
      // same arrangement for every lane, whichever converters feed it
      assign acc[i+1] = acc[i] | ({just[i], 112'h0} >> sh); // [RULE12] [RULE1]
   end

   // ****************************************************************
   // octet sequencer
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } pack_st_e;

   pack_st_e st_q;
   logic [packer_pkg::FRAME_W-1:0] frame_q;
   logic [3:0] idx_q;
   logic [14:0] scr_q;

   octet_if to_buf ();
   octet_if from_buf ();

   wire accept = SAMPLE_VALID && SAMPLE_READY && CE;
   wire [7:0] raw = frame_q[packer_pkg::FRAME_W-1-:8]; // [RULE13]
   wire is_last = ({1'b0, idx_q} == len_q - 5'h01);
   wire scr_use = scrambler_enable && LINK_USER_PHASE; // [RULE10] [RULE11]
   wire [22:0] scr_res = scramble(raw, scr_q);
   wire push = to_buf.valid && to_buf.ready && CE;

   assign busy = (st_q == ST_SEND);
   assign SAMPLE_READY = (st_q == ST_IDLE);
   assign to_buf.valid = busy;
   assign to_buf.data = scr_use ? scr_res[7:0] : raw; // [RULE10] [RULE11]
   assign to_buf.last = is_last;

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= ST_IDLE;
         frame_q <= '0;
         idx_q <= 4'h0;
         len_q <= 5'h00;
      end else if (CE) begin
         case (st_q)
            ST_IDLE: begin
               if (accept) begin
                  frame_q <= acc[packer_pkg::NCONV];
                  len_q <= len_w;
                  idx_q <= 4'h0;
                  st_q <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (push) begin
                  // next octet moves to the top, ascending order
                  frame_q <= frame_q << 8; // [RULE14]
                  idx_q <= idx_q + 4'h1; // [RULE14]
                  if (is_last) begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // scrambler history only advances on scrambled octets
   always_ff @(posedge CLK) begin
      if (RST) begin
         scr_q <= packer_pkg::SCR_SEED;
      end else if (push && scr_use) begin
         scr_q <= scr_res[22:8];
      end
   end

   octet_fifo2 u_buf (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .wr(to_buf),
      .rd(from_buf)
   );

   assign OCT_DATA = from_buf.data;
   assign OCT_LAST = from_buf.last;
   assign OCT_VALID = from_buf.valid;
   assign from_buf.ready = OCT_READY;

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_take;
      accept;
   endsequence
   sequence s_take_live;
      accept && !tp_en && !pdn_q[0];
   endsequence
   sequence s_pad_two;
      accept && !single_mode && (cpl == packer_pkg::CPL_FOUR) && (ser == res + 5'h02);
   endsequence

   // reference values for the checks below, taken before the frame register
   wire [15:0] first_just = justify(SAMPLE_DATA[packer_pkg::SAMPLE_W-1:0], res);
   // after one octet the history holds its own last fifteen output bits
   wire [14:0] scr_next = {scr_q[6:0], to_buf.data};

   AST_FIRST_SLOT: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
      s_take_live |=> (frame_q[127:118] == $past(just[0][15:6])))
      else $error("first sample not at top of frame");
   AST_PDN_ZERO: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
      (accept && pdn_q[0] && !tp_en) |=> (frame_q[127:118] == 10'h000))
      else $error("powered-down slot not zero");
   AST_TPAT: assert property (@(posedge CLK) disable iff (RST) // [RULE9]
      (s_take and (tp_en && !pdn_q[0])) |=> (frame_q[127:118] == $past(tp_just[15:6])))
      else $error("test pattern not in frame");
   AST_TAIL: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
      s_take |=> ((frame_q << {len_q, 3'b000}) == '0))
      else $error("bits beyond frame length not zero");
   AST_SINGLE_LEN: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
      (s_take and single_mode) |=> (len_q == 5'($past(cpl)) * 5'h02))
      else $error("single mode octet count wrong");
   AST_NO_SCR: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
      (push && !LINK_USER_PHASE) |-> (to_buf.data == raw))
      else $error("scrambler active outside user data");
   AST_SCR_OFF: assert property (@(posedge CLK) disable iff (RST) // [RULE10]
      (push && !scrambler_enable) |-> (to_buf.data == raw && $stable(scr_q)) ##1 $stable(scr_q))
      else $error("scrambler used while disabled");
   AST_ASCEND: assert property (@(posedge CLK) disable iff (RST) // [RULE14]
      (push && !is_last) |=> (idx_q == $past(idx_q) + 4'h1 && busy))
      else $error("octet order broken");
   AST_FRAME_END: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
      (s_take ##1 busy[*1]) |-> (len_q != 5'h00) ##[0:400] (push && is_last))
      else $error("frame never completed");

   AST_PAD_TWO: assert property (@(posedge CLK) disable iff (RST) // [RULE2]
      s_pad_two |=> (frame_q[7'(packer_pkg::FRAME_W - 1) - 7'(res) -: 2] == 2'b00))
      else $error("trailing pad bits not zero");
   AST_SINGLE_TOP: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
      (s_take_live and single_mode) |=> (frame_q[packer_pkg::FRAME_W-1-:packer_pkg::SAMPLE_W] == $past(first_just)))
      else $error("single mode slot not left-justified");
   AST_LAST_IDLE: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
      (push && is_last) |=> SAMPLE_READY)
      else $error("sequencer not idle after last octet");
   AST_READY_LOW: assert property (@(posedge CLK) disable iff (RST) // [RULE8]
      s_take |=> !SAMPLE_READY)
      else $error("second sample taken within one frame");
   AST_SCR_MSB: assert property (@(posedge CLK) disable iff (RST) // [RULE10]
      (push && scr_use) |-> (to_buf.data[7] == (raw[7] ^ scr_q[14] ^ scr_q[13])))
      else $error("first scrambled bit wrong");
   AST_SCR_NEXT: assert property (@(posedge CLK) disable iff (RST) // [RULE10]
      (push && scr_use) |=> (scr_q == $past(scr_next)))
      else $error("scrambler history not fed from output");
   // a frozen clock enable must not slip or reorder an octet
   AST_CE_FREEZE: assert property (@(posedge CLK) disable iff (RST) // [RULE14]
      !CE |=> ($stable(frame_q) && $stable(idx_q) && $stable(st_q) && $stable(scr_q)))
      else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* File: hw/octet_fifo2.sv */
// two-entry octet buffer between packer and link layer
// assumes: same clock and clock enable as the packer
`timescale 1ns/1ps
`default_nettype none
module octet_fifo2 (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   octet_if.snk wr,
   octet_if.src rd
);
   logic [8:0] mem_q [0:packer_pkg::FIFO_DEPTH-1];
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;
   wire push = wr.valid && wr.ready && ce;
   wire pop = rd.valid && rd.ready && ce;
   wire full = (cnt_q == 2'(packer_pkg::FIFO_DEPTH));

   assign wr.ready = !full;
   assign rd.valid = (cnt_q != 2'h0);
   assign rd.data = mem_q[rp_q][7:0];
   assign rd.last = mem_q[rp_q][8];

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         mem_q[0] <= 9'h000;
         mem_q[1] <= 9'h000;
      end else begin
         if (push) begin
            mem_q[wp_q] <= {wr.last, wr.data};
            wp_q <= !wp_q;
         end
         if (pop) begin
            rp_q <= !rp_q;
         end
         cnt_q <= 2'(cnt_q + 2'(push) - 2'(pop));
      end
   end

   // a stalled receiver keeps words, never overwrites
   AST_FIFO_HOLD: assert property (@(posedge clk) disable iff (rst)
      (rd.valid && !rd.ready && ce && !push) |=> (rd.data == $past(rd.data) && rd.valid)) // [RULE14]
      else $error("buffered octet changed while stalled");
endmodule
`default_nettype wire

/* File: hw/octet_if.sv */
// one octet stream with valid/ready handshake
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface octet_if;
   logic [7:0] data;
   logic last;
   logic valid;
   logic ready;
   modport src(output data, output last, output valid, input ready);
   modport snk(input data, input last, input valid, output ready);
endinterface
`default_nettype wire

/* File: hw/packer_pkg.sv */
// constants, field layout and reset values of the transport-layer octet packer
// assumes: one clock domain, registers reached over a classic wishbone slave
// ****************************************************************
// Overview of operation
// RULE1: four per lane, equal widths: back-to-back nibbles
// RULE2: width two above resolution: two trailing zeros
// RULE3: two per lane: 10/14 padded, 12/16 unpadded
// RULE4: single mode: two octets per sample, zeros
// RULE5: single mode emits eight or four octets; the code emits sixteen with eight converters
// RULE6: all tail bits are zero
// RULE7: powered-down converter gives all-zero sample
// RULE8: one sample per frame, no high density
// RULE9: test pattern replaces samples when selected
// RULE10: scramble only while scrambler_enable set
// RULE11: scrambler bypassed during sync and alignment
// RULE12: every lane uses the same packing
// RULE13: frame bits leave msb first
// RULE14: octets leave in ascending order, nibble one high
// ****************************************************************
package packer_pkg;
   localparam int NCONV = 8;
   localparam int SAMPLE_W = 16;
   localparam int FRAME_W = NCONV * SAMPLE_W;
   localparam int FIFO_DEPTH = 2;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TPAT = 8'h04;
   localparam logic [7:0] OFS_PDN = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   // control fields: cpl, res and ser one byte each, single, scrambler and test pattern flags in the top byte
   localparam int CPL_LSB = 0;
   localparam int RES_LSB = 8;
   localparam int SER_LSB = 16;
   localparam int SINGLE_BIT = 24;
   localparam int SCR_BIT = 25;
   localparam int TP_BIT = 26;
   localparam logic [31:0] CTRL_MASK = 32'h071f1f0f;
   localparam logic [31:0] CTRL_RST = 32'h00101008;
   localparam logic [15:0] TPAT_RST = 16'h0000;
   localparam logic [7:0] PDN_RST = 8'h00;
   localparam int BUSY_BIT = 0;
   localparam int LEN_LSB = 8;
   // scrambler seed, all ones
   localparam logic [14:0] SCR_SEED = 15'h7fff;
   localparam logic [3:0] CPL_TWO = 4'h2;
   localparam logic [3:0] CPL_FOUR = 4'h4;
   localparam logic [3:0] CPL_EIGHT = 4'h8;
   localparam logic [4:0] W_SINGLE = 5'h10;
   localparam logic [4:0] NIB_RND = 5'h03;
   localparam logic [4:0] NIB_MASK = 5'h1c;
endpackage

/* File: testbench/link_octet_sink.sv */
// model of the link-layer receiver that drains the octet stream
// assumes: same clock as the packer; the bench picks prompt or slow draining
`timescale 1ns/1ps
`default_nettype none
module link_octet_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   output logic oct_ready
);
   logic [1:0] cnt_q;
   // ********
   // draining
   // ********
   // slow mode takes one octet in four, so the two-entry buffer backs up
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 2'h0;
         oct_ready <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         oct_ready <= !slow || (cnt_q == 2'h3);
      end
   end
endmodule
`default_nettype wire

/* File: testbench/tb_jesd_transport_octet_packer.sv */
// self-checking bench for the transport-layer octet packer
// assumes: package, interface, buffer and packer compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_jesd_transport_octet_packer;
   logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0;
   logic SAMPLE_VALID = 1'b0, LINK_USER_PHASE = 1'b1, slow = 1'b0;
   logic [7:0] WB_ADR = 8'h00;
   logic [3:0] WB_SEL = 4'h0;
   logic [31:0] WB_DAT_W = 32'h0, WB_DAT_R;
   logic [127:0] SAMPLE_DATA = 128'h0;
   logic WB_ACK, SAMPLE_READY, OCT_LAST, OCT_VALID, OCT_READY;
   logic [7:0] OCT_DATA;
   int err_total = 0, cmp_count = 0, cpl, res, ser, flen;
   logic single = 1'b0, scr = 1'b0, tp = 1'b0, ph = 1'b1;
   logic [7:0] pdn = 8'h00;
   logic [15:0] tpat = 16'h0;
   logic [14:0] scr_h = packer_pkg::SCR_SEED;
   logic [8:0] exp_q[$], got_q[$];

   always #5 CLK = ~CLK;

   jesd_transport_octet_packer dut (.CLK, .RST, .CE, .WB_CYC, .WB_STB, .WB_WE, .WB_ADR, .WB_SEL,
      .WB_DAT_W, .WB_DAT_R, .WB_ACK, .SAMPLE_DATA, .SAMPLE_VALID, .SAMPLE_READY, .LINK_USER_PHASE,
      .OCT_DATA, .OCT_LAST, .OCT_VALID, .OCT_READY);
   link_octet_sink partner (.clk(CLK), .rst(RST), .slow(slow), .oct_ready(OCT_READY));

   always @(posedge CLK) begin
      if (!RST && CE === 1'b1 && OCT_VALID === 1'b1 && OCT_READY === 1'b1) begin
         got_q.push_back({OCT_LAST, OCT_DATA});
      end
   end

   // ***********
   // bench tasks
   // ***********
   task automatic wrap_up();
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cmp9(input logic [8:0] g, input logic [8:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t octet got %h exp %h", $time, g, e);
      end
   endtask

   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t reg got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge CLK);
      WB_CYC <= 1'b1;
      WB_STB <= 1'b1;
      WB_WE <= we;
      WB_ADR <= a;
      WB_SEL <= 4'hf;
      WB_DAT_W <= d;
      // no wait limit of its own: only the watchdog ends a hung request
      do begin
         @(posedge CLK);
      end while (WB_ACK !== 1'b1);
      r = WB_DAT_R;
      WB_CYC <= 1'b0;
      WB_STB <= 1'b0;
   endtask

   function automatic logic [127:0] mk(input logic [15:0] seed, input int r);
      logic [127:0] s;
      s = 128'h0;
      for (int i = 0; i < 8; i++) s[16*i+:16] = (seed ^ (16'h1357 * i[15:0])) & ((16'h1 << r) - 16'h1);
      return s;
   endfunction

   // expected octets: slots msb first, zero padding, optional self-sync scrambling
   task automatic model(input logic [127:0] s);
      int w, len, p;
      logic [127:0] b;
      logic [15:0] v;
      logic [7:0] o;
      w = single ? 16 : (cpl == 2 ? (res + 3) / 4 * 4 : ser);
      len = cpl * w / 8;
      flen = len;
      b = 128'h0; // tail and padding bits stay zero
      p = 127;
      for (int i = 0; i < cpl; i++) begin
         v = pdn[i] ? 16'h0 : (tp ? tpat : s[16*i+:16]);
         for (int k = res - 1; k >= 0; k--) begin
            b[p] = v[k];
            p--;
         end
         p -= w - res;
      end
      for (int j = 0; j < len; j++) begin
         o = b[127-8*j-:8];
         for (int k = 7; k >= 0 && scr && ph; k--) begin
            o[k] = o[k] ^ scr_h[13] ^ scr_h[14];
            scr_h = {scr_h[13:0], o[k]};
         end
         exp_q.push_back({j == len - 1, o});
      end
   endtask

   task automatic send(input logic [127:0] s);
      int n;
      model(s);
      @(posedge CLK);
      SAMPLE_VALID <= 1'b1;
      SAMPLE_DATA <= s; // one sample per converter in every frame
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (SAMPLE_READY !== 1'b1 && n < 100);
      SAMPLE_VALID <= 1'b0;
   endtask

   task automatic drain();
      int n;
      n = 0;
      // freeze the packer mid-frame; nothing may be lost or reordered
      CE <= 1'b0;
      repeat (3) @(posedge CLK);
      CE <= 1'b1;
      while (got_q.size() < exp_q.size() && n < 500) begin
         @(posedge CLK);
         n++;
      end
      repeat (4) @(posedge CLK);
      while (exp_q.size()) cmp9(got_q.size() ? got_q.pop_front() : 9'h1ff, exp_q.pop_front());
      while (got_q.size()) cmp9(got_q.pop_front(), 9'bx);
   endtask

   task automatic run_cfg(input int c, input int r, input int sr, input logic sg);
      logic [31:0] d;
      cpl = c;
      res = r;
      ser = sr;
      single = sg;
      slow <= ~slow;
      wb(1'b1, packer_pkg::OFS_CTRL, {5'h0, tp, scr, sg, 3'h0, sr[4:0], 3'h0, r[4:0], 4'h0, c[3:0]}, d);
      // back to back frames, in slow runs the second one waits on a stalled buffer
      send(mk(16'h5a3c ^ r[15:0], r));
      send(mk(16'hc3a5, r));
      drain();
      // idle again, status shows the octet count of the last frame
      wb(1'b0, packer_pkg::OFS_STATUS, 32'h0, d);
      cmp32(d, 32'(flen) << packer_pkg::LEN_LSB);
   endtask

   // *********
   // scenarios
   // *********
   task automatic t_regs();
      logic [31:0] r;
      wb(1'b0, packer_pkg::OFS_CTRL, 32'h0, r);
      cmp32(r, packer_pkg::CTRL_RST);
      wb(1'b0, packer_pkg::OFS_TPAT, 32'h0, r);
      cmp32(r, 32'h0);
      wb(1'b0, packer_pkg::OFS_PDN, 32'h0, r);
      cmp32(r, 32'h0);
      wb(1'b1, packer_pkg::OFS_CTRL, 32'hffffffff, r);
      wb(1'b0, packer_pkg::OFS_CTRL, 32'h0, r);
      cmp32(r, packer_pkg::CTRL_MASK);
      // unmapped place must swallow writes and read as zero
      wb(1'b1, 8'h40, 32'hffffffff, r);
      wb(1'b0, 8'h40, 32'h0, r);
      cmp32(r, 32'h0);
   endtask

   task automatic t_pdn_tp();
      logic [31:0] r;
      pdn = 8'h05;
      wb(1'b1, packer_pkg::OFS_PDN, {24'h0, pdn}, r);
      run_cfg(4, 12, 12, 1'b0);
      tp = 1'b1;
      tpat = 16'h0abc;
      pdn = 8'h02;
      wb(1'b1, packer_pkg::OFS_TPAT, {16'h0, tpat}, r);
      wb(1'b1, packer_pkg::OFS_PDN, {24'h0, pdn}, r);
      run_cfg(4, 12, 12, 1'b0);
      tp = 1'b0;
      pdn = 8'h00;
      wb(1'b1, packer_pkg::OFS_PDN, 32'h0, r);
   endtask

   task automatic t_scr();
      scr = 1'b1;
      ph = 1'b0;
      LINK_USER_PHASE <= 1'b0;
      run_cfg(4, 16, 16, 1'b0);
      ph = 1'b1;
      LINK_USER_PHASE <= 1'b1;
      run_cfg(4, 16, 16, 1'b0);
      run_cfg(2, 10, 12, 1'b0);
   endtask

   initial begin
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      t_regs();
      run_cfg(4, 10, 10, 1'b0);
      run_cfg(4, 16, 16, 1'b0);
      run_cfg(4, 12, 14, 1'b0);
      run_cfg(4, 10, 12, 1'b0);
      run_cfg(2, 10, 10, 1'b0);
      run_cfg(2, 14, 16, 1'b0);
      run_cfg(2, 12, 12, 1'b0);
      run_cfg(2, 16, 16, 1'b0);
      run_cfg(8, 14, 14, 1'b0);
      run_cfg(8, 10, 10, 1'b1);
      run_cfg(4, 12, 14, 1'b1);
      run_cfg(2, 14, 14, 1'b1);
      t_pdn_tp();
      t_scr();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge CLK);
      err_total++;
      wrap_up();
   end
endmodule
`default_nettype wire
